// File: dcd_map.svh
/*
  register map, field positions and reset values of the
  down counter divider.
  assumes a 32-bit axi4-lite slave with word-aligned registers.
*/
`ifndef DCD_MAP_SVH
`define DCD_MAP_SVH

// byte offsets
`define DCD_CTRL_OFS     12'h000
`define DCD_DIVISOR_OFS  12'h004
`define DCD_TBDIV_OFS    12'h008
`define DCD_STATUS_OFS   12'h00C
`define DCD_COUNT_OFS    12'h010

// control fields
`define DCD_CTRL_START   0
`define DCD_CTRL_STOP    1
`define DCD_CTRL_EXTSRC  2
`define DCD_CTRL_EDGE    3
`define DCD_GATE_LSB     4
`define DCD_OUT_LSB      8

// reset values
`define DCD_CTRL_RST     32'h0000_0004
`define DCD_DIVISOR_RST  32'h0000_0002
`define DCD_TBDIV_RST    32'h0000_0001

// status fields
`define DCD_ST_RUN       0
`define DCD_ST_ARMED     1
`define DCD_ST_OUT       2

`endif

// File: dcd_pkg.sv
/*
  types of the down counter divider.
  assumes dcd_map.svh for numbers.
*/
package dcd_pkg;
  typedef enum logic [2:0] {
    DCD_GATE_NONE = 3'h0,
    DCD_GATE_HIGH = 3'h1,
    DCD_GATE_LOW  = 3'h2,
    DCD_GATE_RISE = 3'h3,
    DCD_GATE_FALL = 3'h4
  } dcd_gate_e;

  typedef enum logic [1:0] {
    DCD_OUT_HPULSE = 2'h0,
    DCD_OUT_LPULSE = 2'h1,
    DCD_OUT_HTOG   = 2'h2,
    DCD_OUT_LTOG   = 2'h3
  } dcd_out_e;

  typedef enum logic [2:0] {
    DCD_ST_IDLE = 3'b001,
    DCD_ST_WAIT = 3'b010,
    DCD_ST_RUN  = 3'b100
  } dcd_state_e;
endpackage

// File: dcd_core.sv
/*
  counting core: edge pick, gating, down count, reload and output shaping.
  assumes synchronous inputs and configuration held stable while running.
*/
`timescale 1ns/100ps
`include "dcd_map.svh"
module dcd_core
  import dcd_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_start,
  input  wire logic        i_stop,
  input  wire logic        i_ext_src,
  input  wire logic        i_src_fall,
  input  wire logic [2:0]  i_gate_mode,
  input  wire logic [1:0]  i_out_mode,
  input  wire logic [31:0] i_divisor,
  input  wire logic [31:0] i_tb_div,
  input  wire logic        i_counter_source_input,
  input  wire logic        i_counter_gate_input,
  output logic             o_counter_output,
  output logic             o_running,
  output logic             o_armed,
  output logic [31:0]      o_count
);
  dcd_state_e  state_q, state_d;
  logic [31:0] cnt_q, tb_q;
  logic        src_q, gate_q, tog_q, pulse_q, tb_tick_q;
  logic        src_edge, gate_ok, tick, tc, gate_start;
  logic [31:0] div_eff;

  // internal timebase: one tick every tb_div core cycles
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || state_q == DCD_ST_IDLE) begin
      tb_q      <= 32'h0000_0000;
      tb_tick_q <= 1'b0;
    end else begin
      tb_tick_q <= (tb_q + 32'h0000_0001 >= i_tb_div);
      tb_q      <= (tb_q + 32'h0000_0001 >= i_tb_div) ? 32'h0000_0000
                                                      : tb_q + 32'h0000_0001;
    end
  end

  // input history for edge detection
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      src_q  <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      src_q  <= i_counter_source_input;
      gate_q <= i_counter_gate_input;
    end
  end

  assign src_edge = i_src_fall ? (src_q & ~i_counter_source_input)
                               : (~src_q & i_counter_source_input);
  assign tick = i_ext_src ? src_edge : tb_tick_q;
  assign gate_ok = (i_gate_mode == DCD_GATE_HIGH) ? i_counter_gate_input :
                   (i_gate_mode == DCD_GATE_LOW)  ? ~i_counter_gate_input :
                   1'b1;
  assign gate_start =
    (i_gate_mode == DCD_GATE_RISE) ? (~gate_q & i_counter_gate_input) :
    (i_gate_mode == DCD_GATE_FALL) ? (gate_q & ~i_counter_gate_input) :
    1'b1;
  assign div_eff = (i_divisor == 32'h0000_0000) ? 32'h0000_0001 : i_divisor;
  assign tc = (state_q == DCD_ST_RUN) && gate_ok && tick
              && (cnt_q == 32'h0000_0001);

  // start, wait for gate, run, stop
  always_comb begin
    state_d = state_q;
    case (state_q)
      DCD_ST_IDLE: begin
        if (i_start) begin
          state_d = DCD_ST_WAIT;
        end
      end
      DCD_ST_WAIT: begin
        if (i_stop) begin
          state_d = DCD_ST_IDLE;
        end else if (gate_start) begin
          state_d = DCD_ST_RUN;
        end
      end
      DCD_ST_RUN: begin
        if (i_stop) begin
          state_d = DCD_ST_IDLE;
        end
      end
      default: state_d = DCD_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_q <= DCD_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cnt_q <= 32'h0000_0001;
    end else if (state_q != DCD_ST_RUN) begin
      cnt_q <= div_eff;
    end else if (tc) begin
      cnt_q <= div_eff;
    end else if (gate_ok && tick) begin
      cnt_q <= cnt_q - 32'h0000_0001;
    end
  end

  // pulse lasts one source cycle: held until the next counting tick
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || state_q == DCD_ST_IDLE) begin
      pulse_q <= 1'b0;
      tog_q   <= 1'b0;
    end else begin
      if (tc) begin
        pulse_q <= 1'b1;
      end else if (tick) begin
        pulse_q <= 1'b0;
      end
      if (tc) begin
        tog_q <= ~tog_q;
      end
    end
  end

  // output shaping by mode
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_counter_output <= 1'b0;
    end else begin
      case (i_out_mode)
        DCD_OUT_HPULSE: o_counter_output <= tc | (pulse_q & ~tick);
        DCD_OUT_LPULSE: o_counter_output <= ~(tc | (pulse_q & ~tick));
        DCD_OUT_HTOG:   o_counter_output <= tc ? ~tog_q : tog_q;
        default:        o_counter_output <= tc ? tog_q : ~tog_q;
      endcase
    end
  end

  assign o_running = (state_q == DCD_ST_RUN);
  assign o_armed   = (state_q == DCD_ST_WAIT);
  assign o_count   = cnt_q;
endmodule

// File: dcd_top.sv
/*
  down counter divider with axi4-lite register slave.
  assumes synchronous pins, one clock, single-beat axi4-lite master.
*/
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
// Behaviour
// - external source bit set counts source pin edges
// - divisor sets cycles down to terminal count
// - gate mode 0 starts on software start
// - gate mode 1 counts while gate high
// - gate mode 2 counts while gate low
// - gate mode 3 starts on gate rise
// - gate mode 4 starts on gate fall
// - source edge selects rising or falling
// - output mode 0 one-cycle high pulse
// - output mode 1 one-cycle low pulse
// - output mode 2 toggles high first
// - output mode 3 toggles low first
// - pulse modes divide input by divisor
// - toggle modes divide by twice divisor
`timescale 1ns/100ps
`include "dcd_map.svh"
module dcd_top
  import dcd_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        i_counter_source_input,
  input  wire logic        i_counter_gate_input,
  output logic             o_counter_output
);
  logic [31:0] ctrl_q, div_q, tbdiv_q;
  logic [11:0] awaddr_q;
  logic        aw_q, w_q, start_q, stop_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        running, armed;
  logic [31:0] count;
  logic        do_write, wr_ctrl, wr_div, wr_tb, wr_ok;
  logic        rd_ctrl, rd_div, rd_tb, rd_st, rd_cnt, rd_ok;
  logic [31:0] rd_mux;

  // byte-lane merge used for every writable register
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // write channels are taken independently, response after both
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign do_write      = aw_q && w_q && !s_axi_bvalid;

  // write address decode
  assign wr_ctrl = (awaddr_q == `DCD_CTRL_OFS);
  assign wr_div  = (awaddr_q == `DCD_DIVISOR_OFS);
  assign wr_tb   = (awaddr_q == `DCD_TBDIV_OFS);
  assign wr_ok   = wr_ctrl || wr_div || wr_tb
                   || (awaddr_q == `DCD_STATUS_OFS)
                   || (awaddr_q == `DCD_COUNT_OFS);

  // capture address and data
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_q <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers and start/stop strobes
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ctrl_q  <= `DCD_CTRL_RST;
      div_q   <= `DCD_DIVISOR_RST;
      tbdiv_q <= `DCD_TBDIV_RST;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
    end else begin
      start_q <= do_write && wr_ctrl && wstrb_q[0]
                 && wdata_q[`DCD_CTRL_START];
      stop_q  <= do_write && wr_ctrl && wstrb_q[0]
                 && wdata_q[`DCD_CTRL_STOP];
      if (do_write && wr_ctrl) begin
        ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_037C;
      end
      if (do_write && wr_div) begin
        div_q <= merge(div_q, wdata_q, wstrb_q);
      end
      if (do_write && wr_tb) begin
        tbdiv_q <= merge(tbdiv_q, wdata_q, wstrb_q);
      end
    end
  end

  // read decode
  assign rd_ctrl = (s_axi_araddr == `DCD_CTRL_OFS);
  assign rd_div  = (s_axi_araddr == `DCD_DIVISOR_OFS);
  assign rd_tb   = (s_axi_araddr == `DCD_TBDIV_OFS);
  assign rd_st   = (s_axi_araddr == `DCD_STATUS_OFS);
  assign rd_cnt  = (s_axi_araddr == `DCD_COUNT_OFS);
  assign rd_ok   = rd_ctrl || rd_div || rd_tb || rd_st || rd_cnt;
  assign rd_mux  = rd_ctrl ? ctrl_q :
                   rd_div  ? div_q :
                   rd_tb   ? tbdiv_q :
                   rd_st   ? {29'h0000_0000, o_counter_output, armed,
                              running} :
                   rd_cnt  ? count : 32'h0000_0000;
  assign s_axi_arready = !s_axi_rvalid;

  // read data channel
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // counting core
  dcd_core u_core (
    .i_core_clk             (i_core_clk),
    .i_rst_n                (i_rst_n),
    .i_start                (start_q),
    .i_stop                 (stop_q),
    .i_ext_src              (ctrl_q[`DCD_CTRL_EXTSRC]),
    .i_src_fall             (ctrl_q[`DCD_CTRL_EDGE]),
    .i_gate_mode            (ctrl_q[`DCD_GATE_LSB +: 3]),
    .i_out_mode             (ctrl_q[`DCD_OUT_LSB +: 2]),
    .i_divisor              (div_q),
    .i_tb_div               (tbdiv_q),
    .i_counter_source_input (i_counter_source_input),
    .i_counter_gate_input   (i_counter_gate_input),
    .o_counter_output       (o_counter_output),
    .o_running              (running),
    .o_armed                (armed),
    .o_count                (count)
  );
endmodule

// File: dcd_sva.sv
/*
  assertions on the pins and register writes of the divider.
  assumes whole-word writes, address and data offered together.
*/
`timescale 1ns/100ps
module dcd_sva (
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        i_counter_source_input,
  input wire logic        i_counter_gate_input,
  input wire logic        o_counter_output
);
  logic       wr, ev, se, ext_q, fal_q, pv_q, src_q, out_q;
  logic [1:0] om_q;
  logic [2:0] gm_q;
  logic [3:0] wq_q, ea_q;
  logic [7:0] dv_q, tc_q;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // taken write, selected source edge, active output event
  assign wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  assign se = (src_q ^ i_counter_source_input)
            & (i_counter_source_input ^ fal_q);
  assign ev = (o_counter_output ^ out_q)
            & (om_q[1] | (o_counter_output ^ om_q[0]));
  // ages since write and edge, edges between events, shadow config
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      src_q <= 1'b0;
      out_q <= 1'b0;
      wq_q  <= 4'h0;
      ea_q  <= 4'hf;
      tc_q  <= 8'h00;
      pv_q  <= 1'b0;
      {om_q, gm_q, fal_q, ext_q} <= 7'h01; // register reset: source pin
      dv_q  <= 8'h02; // register reset divisor
    end else begin
      src_q <= i_counter_source_input;
      out_q <= o_counter_output;
      wq_q  <= wr ? 4'h0 : wq_q + {3'h0, wq_q != 4'hf};
      ea_q  <= se ? 4'h0 : ea_q + {3'h0, ea_q != 4'hf};
      tc_q  <= (ev | wr) ? 8'h00 : tc_q + {7'h00, se};
      pv_q  <= ~wr & (pv_q | ev);
      if (wr && s_axi_awaddr == 12'h000) begin
        {om_q, gm_q, fal_q, ext_q} <= {s_axi_wdata[9:8], s_axi_wdata[6:2]};
      end
      if (wr && s_axi_awaddr == 12'h004) begin
        dv_q <= s_axi_wdata[7:0];
      end
    end
  end
  AST_OUT_RESET: assert property ($rose(i_rst_n) |-> !o_counter_output)
    else $error("output high after reset");
  AST_EXT_EDGE: assert property (ext_q && wq_q > 4'h4
    && $changed(o_counter_output) |-> ea_q <= 4'h3)
    else $error("output moved away from a source edge");
  AST_HPULSE_END: assert property (ext_q && om_q == 2'h0 && gm_q == 3'h0
    && dv_q > 8'h01 && wq_q > 4'h4 && se && o_counter_output
    |-> ##[1:3] !o_counter_output) else $error("high pulse too long");
  AST_LPULSE_END: assert property (ext_q && om_q == 2'h1 && gm_q == 3'h0
    && dv_q > 8'h01 && wq_q > 4'h4 && se && !o_counter_output
    |-> ##[1:3] o_counter_output) else $error("low pulse too long");
  AST_PULSE_DIV: assert property (ext_q && gm_q == 3'h0 && !om_q[1]
    && pv_q && ev |-> tc_q == dv_q) else $error("pulse period off");
  AST_TOG_DIV: assert property (ext_q && gm_q == 3'h0 && om_q[1]
    && pv_q && ev |-> tc_q == dv_q) else $error("toggle period off");
  AST_GATE_HIGH: assert property ((wq_q > 4'h4 && gm_q == 3'h1
    && !i_counter_gate_input)[*6] |-> $stable(o_counter_output))
    else $error("counted while gate low");
  AST_GATE_LOW: assert property ((wq_q > 4'h4 && gm_q == 3'h2
    && i_counter_gate_input)[*6] |-> $stable(o_counter_output))
    else $error("counted while gate high");
  cover property (ev && pv_q && om_q[1]);
  cover property (gm_q == 3'h4 && ev);
  cover property (ext_q && fal_q && ev);
endmodule

// File: dcd_pin_model.sv
/*
  external sources on the source and gate pins.
  assumes pins are sampled by the same core clock.
*/
`timescale 1ns/100ps
module dcd_pin_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_run,
  input  wire logic [7:0] i_half,
  input  wire logic       i_gate_lvl,
  output logic            o_src,
  output logic            o_gate
);
  logic [7:0] cnt_q;
  logic       ph_q;
  logic       wrap;
  assign wrap = cnt_q + 8'h01 >= i_half;
  // square wave of two half periods, low while idle
  always_ff @(posedge i_core_clk) begin
    cnt_q <= (!i_run || wrap) ? 8'h00 : cnt_q + 8'h01;
    ph_q  <= i_run & (ph_q ^ wrap);
  end
  assign o_src  = i_run & ph_q;
  assign o_gate = i_gate_lvl;
endmodule

// File: tb.sv
/*
  self-checking bench of the down counter divider.
  assumes dcd_top, dcd_sva and dcd_pin_model.
*/
`timescale 1ns/100ps
`include "dcd_map.svh"
module tb;
  logic        i_core_clk, i_rst_n, awvalid, wvalid, arvalid;
  logic        run, gate_lvl, src, gate, out, awready, wready;
  logic        bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  half;
  int          mismatches = 0, checks_done = 0, cyc = 0, w, p;
  // ext, edge, out mode, divisor, timebase div, half, width, period
  int rw [5][8] = '{'{1, 0, 0, 3, 1, 4, 8, 24}, '{1, 1, 1, 2, 1, 5, 10, 20},
    '{1, 0, 2, 3, 1, 4, 24, 48}, '{0, 0, 3, 4, 3, 0, 12, 24},
    '{0, 0, 0, 5, 2, 0, 2, 10}};
  dcd_top dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .i_counter_source_input(src), .i_counter_gate_input(gate),
    .o_counter_output(out));
  dcd_pin_model pm_u (.i_core_clk(i_core_clk), .i_run(run), .i_half(half),
    .i_gate_lvl(gate_lvl), .o_src(src), .o_gate(gate));
  task automatic chk(input string n, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, dn;
    dn = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!dn) begin
      @(negedge i_core_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      dn = bvalid;
      if (dn) chk("bresp", er, bresp);
      @(posedge i_core_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    logic ta, dn;
    dn = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!dn) begin
      @(negedge i_core_clk);
      ta = arvalid && arready;
      dn = rvalid;
      if (dn) chk("rdata", e, rdata);
      if (dn) chk("rresp", er, rresp);
      @(posedge i_core_clk);
      if (ta) arvalid <= 1'b0;
    end
  endtask
  task automatic go(input int ext, fal, gm, om);
    logic [31:0] c;
    c = (ext << `DCD_CTRL_EXTSRC) | (fal << `DCD_CTRL_EDGE)
      | (gm << `DCD_GATE_LSB) | (om << `DCD_OUT_LSB);
    wr(`DCD_CTRL_OFS, c, 2'h0);
    wr(`DCD_CTRL_OFS, c | 32'h0000_0001, 2'h0);
  endtask
  // cycles at active level, then cycles to the next active event
  task automatic meas(input int om, output int w, output int p);
    logic lv;
    lv = (om % 2 == 0);
    w = 0;
    while (out !== !lv) @(negedge i_core_clk);
    while (out !== lv) @(negedge i_core_clk);
    while (out === lv) begin
      @(negedge i_core_clk);
      w++;
    end
    p = w;
    while (out !== lv) begin
      @(negedge i_core_clk);
      p++;
    end
    @(posedge i_core_clk);
  endtask
  task automatic stop(input int om);
    wr(`DCD_CTRL_OFS, (om << `DCD_OUT_LSB) | 2, 2'h0);
    repeat (20) @(negedge i_core_clk);
    // idle level
    chk("idle", om % 2, out);
    @(posedge i_core_clk);
  endtask
  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // clock
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // hang guard
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    {i_rst_n, awvalid, wvalid, arvalid, run, gate_lvl} = '0;
    {awaddr, araddr, wdata, half} = '0;
    repeat (8) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    rdc(`DCD_CTRL_OFS, 32'h0000_0004, 2'h0);
    rdc(`DCD_DIVISOR_OFS, 32'h0000_0002, 2'h0);
    rdc(`DCD_TBDIV_OFS, 32'h0000_0001, 2'h0);
    rdc(12'h0fc, 32'h0000_0000, 2'h2);
    wr(12'h0fc, 32'h0000_00ff, 2'h2);
    for (int r = 0; r < 5; r++) begin
      run <= (rw[r][0] != 0);
      half <= 8'(rw[r][5]);
      wr(`DCD_DIVISOR_OFS, rw[r][3], 2'h0);
      wr(`DCD_TBDIV_OFS, rw[r][4], 2'h0);
      go(rw[r][0], rw[r][1], 0, rw[r][2]);
      meas(rw[r][2], w, p);
      chk("width", rw[r][6], w);
      chk("period", rw[r][7], p);
      stop(rw[r][2]);
    end
    for (int g = 1; g < 5; g++) begin
      gate_lvl <= (g == 2 || g == 4);
      run <= 1'b1;
      half <= 8'h04;
      wr(`DCD_DIVISOR_OFS, 32'h0000_0002, 2'h0);
      go(1, 0, g, 2);
      repeat (60) @(negedge i_core_clk);
      chk("held", 0, out);
      @(posedge i_core_clk);
      // blocked by the gate: running in level modes, armed in edge modes
      rdc(`DCD_STATUS_OFS, (g > 2) ? 2 : 1, 2'h0);
      rdc(`DCD_COUNT_OFS, 32'h0000_0002, 2'h0);
      gate_lvl <= !(g == 2 || g == 4);
      meas(2, w, p);
      chk("gated", 16, w);
      stop(2);
    end
    // mid-run reset: a running toggle divider falls back to defaults
    wr(`DCD_DIVISOR_OFS, 32'h0000_0003, 2'h0);
    go(1, 0, 0, 2);
    repeat (40) @(negedge i_core_clk);
    chk("run out", 1, out);
    @(posedge i_core_clk);
    i_rst_n <= 1'b0;
    repeat (8) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    repeat (2) begin
      @(negedge i_core_clk);
      chk("reset out", 0, out);
    end
    @(posedge i_core_clk);
    rdc(`DCD_CTRL_OFS, 32'h0000_0004, 2'h0);
    rdc(`DCD_DIVISOR_OFS, 32'h0000_0002, 2'h0);
    rdc(`DCD_STATUS_OFS, 32'h0000_0000, 2'h0);
    // restart on the reset divisor of two, source period eight
    go(1, 0, 0, 0);
    meas(0, w, p);
    chk("width", 8, w);
    chk("period", 16, p);
    stop(0);
    print_verdict();
  end
endmodule
bind dcd_top dcd_sva chk_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .i_counter_source_input(i_counter_source_input),
  .i_counter_gate_input(i_counter_gate_input),
  .o_counter_output(o_counter_output));
